// ---- src/let_timing_defines.vh ----
// Constants for the line exposure timing block: register map, fields, resets and timing counts
//
// Notes on behaviour
// R1 - Trigger off: internal line rate and exposure, free running, no outside sync.
// R2 - Internal mode: new line rate shortens exposure so it fits the period.
// R3 - Internal mode: a new exposure is limited by the current line period.
// R4 - Line period is never shorter than the sensor readout period.
// R5 - Readout after each exposure lasts 14 microseconds.
// R6 - Pulse-width mode: line sync alone sets period and exposure, no line timer.
// R7 - Pulse-width mode: rising edge starts exposure, falling edge ends it, starts readout.
// R8 - Source keeps line rate at most 1/(exposure + 1500 ns) in pulse-width mode.
// R9 - Timed triggered mode: each falling edge starts a programmed-length exposure.
// R10 - Source keeps high part above 6 us and low part above 1500 ns.
// R11 - Timed triggered mode: one extra falling edge during exposure is latched.
// R12 - Line rate is accepted only while the external trigger is off.
// R13 - Reject pairing with period not above exposure + 1500 ns; flag error.
// R14 - Triggers above the maximum line rate are dropped; lines stay at the maximum.
// R15 - Internal line rate ranges from 1 Hz to 50 kHz.
// R16 - Maximum line rate depends on link configuration and pixel format.
// R17 - Region widths and link clock limit the line rate, capped at 70 kHz.
// R18 - Pulse-width only with trigger on; programmed exposure used in internal and timed modes, not in pulse-width mode.
// R19 - Exposure programmable from 8 us to 3000 us, also bounded by line rate.
// R20 - Periods and exposures are counted in whole cycles of the system clock.
`ifndef LET_TIMING_DEFINES_VH
`define LET_TIMING_DEFINES_VH

`define LET_OFF_CTRL 8'h00
`define LET_OFF_RATE 8'h04
`define LET_OFF_EXPO 8'h08
`define LET_OFF_STAT 8'h0c
`define LET_OFF_REG0 8'h10
`define LET_OFF_PERIOD 8'h20
`define LET_OFF_MAXR 8'h24

`define LET_CTRL_TRIG 0
`define LET_CTRL_WIDTH 1
`define LET_CTRL_CFG_LO 2
`define LET_CTRL_DECA_FMT 4
`define LET_CTRL_HALF 5
`define LET_CTRL_CNT_LO 6

`define LET_STAT_ERR 0
`define LET_STAT_DROP 1
`define LET_STAT_EXPO 2
`define LET_STAT_READ 3
`define LET_STAT_PEND 4

`define LET_RST_CTRL 8'h00
`define LET_RST_RATE 16'h03e8
`define LET_RST_EXPO 12'h064
`define LET_RST_REGION 16'h0400

`define LET_CLK_HZ 32'h017d7840
`define LET_CLK_NS 32'h00000028
`define LET_READOUT_NS 32'h000036b0
`define LET_READOUT_CYC ((`LET_READOUT_NS + `LET_CLK_NS - 32'h1) / `LET_CLK_NS)
`define LET_GAP_NS 32'h000005dc
`define LET_GAP_CYC ((`LET_GAP_NS + `LET_CLK_NS - 32'h1) / `LET_CLK_NS)
`define LET_CYC_PER_US (32'h000003e8 / `LET_CLK_NS)

`define LET_RATE_MIN 32'h00000001
`define LET_RATE_MAX 32'h0000c350
`define LET_RATE_BASE 32'h00002710
`define LET_RATE_MED 32'h00004e20
`define LET_RATE_DECA_A 32'h0000c350
`define LET_RATE_DECA_B 32'h000084d0
`define LET_RATE_CAP 32'h00011170
`define LET_LINK10_FULL 32'h32a9f880
`define LET_LINK10_HALF 32'h1954fc40
`define LET_EXPO_MIN_US 32'h00000008
`define LET_EXPO_MAX_US 32'h00000bb8

`endif

// ---- src/let_timing.v ----
// Line period and exposure window timer with APB register access
`timescale 1ns/1ps
`include "let_timing_defines.vh"

module let_timing #(
	parameter NREG = 4
)
(
	// Clock, reset, enable
	input wire clk_sys,
	input wire nrst,
	input wire ce,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Line sync from the far side
	input wire line_sync_in,
	// Sensor timing
	output reg exposing,
	output reg readout,
	output reg line_start
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXPO = 1'b1;

	reg [7:0] ctrl_ff;
	reg [15:0] rate_ff;
	reg [11:0] expo_ff;
	reg err_ff;
	reg drop_ff;
	reg pend_ff;
	reg state_ff;
	reg sync_prev_ff;
	reg [31:0] line_cnt_ff;
	reg [31:0] exp_cnt_ff;
	reg [31:0] rd_cnt_ff;
	wire [15:0] region_ff [0:NREG-1];

	wire access = psel & penable & ce;
	wire wr = access & pwrite;
	wire trig_en = ctrl_ff[`LET_CTRL_TRIG];
	wire pw_mode = ctrl_ff[`LET_CTRL_WIDTH];
	wire [1:0] link_cfg = ctrl_ff[`LET_CTRL_CFG_LO+1:`LET_CTRL_CFG_LO];
	wire [1:0] region_cnt = ctrl_ff[`LET_CTRL_CNT_LO+1:`LET_CTRL_CNT_LO];

	// Rate limits from link configuration and region widths
	reg [31:0] width_sum;
	reg [31:0] cfg_max;
	reg [31:0] f10;
	reg [31:0] aoi_max;
	reg [31:0] max_rate;
	reg [31:0] eff_rate;
	reg [31:0] period;
	reg [31:0] min_space;
	reg [31:0] exp_req_cyc;
	reg [31:0] exp_lim_cyc;
	reg [31:0] exp_eff_cyc;
	integer i;

	always @*
	begin
		width_sum = 32'h0;
		for (i = 0; i < NREG; i = i + 1)
			if (i <= region_cnt)
				width_sum = width_sum + {16'h0, region_ff[i]};
		case (link_cfg) // R16
			2'd0: cfg_max = `LET_RATE_BASE;
			2'd1: cfg_max = `LET_RATE_MED;
			2'd2: cfg_max = `LET_RATE_CAP;
			default: cfg_max = ctrl_ff[`LET_CTRL_DECA_FMT] ? `LET_RATE_DECA_A : `LET_RATE_DECA_B;
		endcase
		case (link_cfg) // R17
			2'd0: f10 = 32'ha;
			2'd1: f10 = 32'h5;
			2'd2: f10 = 32'h3;
			default: f10 = 32'h2;
		endcase
		if (width_sum == 32'h0)
			aoi_max = `LET_RATE_CAP;
		else
			aoi_max = (ctrl_ff[`LET_CTRL_HALF] ? `LET_LINK10_HALF : `LET_LINK10_FULL) / (f10 * width_sum); // R17
		if (aoi_max > `LET_RATE_CAP)
			aoi_max = `LET_RATE_CAP; // R17
		max_rate = `LET_RATE_MAX; // R15
		if (cfg_max < max_rate)
			max_rate = cfg_max;
		if (aoi_max < max_rate)
			max_rate = aoi_max;
		if (max_rate < `LET_RATE_MIN)
			max_rate = `LET_RATE_MIN;
		eff_rate = ({16'h0, rate_ff} < max_rate) ? {16'h0, rate_ff} : max_rate;
		period = `LET_CLK_HZ / eff_rate; // R20
		if (period < `LET_READOUT_CYC)
			period = `LET_READOUT_CYC; // R4
		min_space = `LET_CLK_HZ / max_rate; // R14
		if (min_space < `LET_READOUT_CYC)
			min_space = `LET_READOUT_CYC; // R4
		exp_req_cyc = {20'h0, expo_ff} * `LET_CYC_PER_US; // R20
		exp_lim_cyc = period - `LET_GAP_CYC - 32'h1;
		// Clipping only applies with the internal line timer in charge
		if (!trig_en && exp_req_cyc > exp_lim_cyc)
			exp_eff_cyc = exp_lim_cyc; // R2
		else
			exp_eff_cyc = exp_req_cyc;
	end

	// Write checks
	wire [31:0] wexp_cyc = pwdata * `LET_CYC_PER_US;
	wire rate_ok = !trig_en && pwdata >= `LET_RATE_MIN && pwdata <= `LET_RATE_MAX; // R12 R15
	wire expo_range = pwdata >= `LET_EXPO_MIN_US && pwdata <= `LET_EXPO_MAX_US; // R19
	wire expo_ok = expo_range && (trig_en || period > wexp_cyc + `LET_GAP_CYC); // R3 R13
	wire sel_ctrl = paddr == `LET_OFF_CTRL;
	wire sel_rate = paddr == `LET_OFF_RATE;
	wire sel_expo = paddr == `LET_OFF_EXPO;
	wire sel_stat = paddr == `LET_OFF_STAT;
	wire sel_reg = paddr >= `LET_OFF_REG0 && paddr < `LET_OFF_REG0 + NREG * 4 && paddr[1:0] == 2'b00;
	wire sel_per = paddr == `LET_OFF_PERIOD;
	wire sel_maxr = paddr == `LET_OFF_MAXR;
	wire mapped = sel_ctrl | sel_rate | sel_expo | sel_stat | sel_reg | sel_per | sel_maxr;
	wire ro_hit = sel_per | sel_maxr;
	wire reject = pwrite & ((sel_rate & !rate_ok) | (sel_expo & !expo_ok) | ro_hit); // R12 R13
	wire wr_ctrl = wr & sel_ctrl;

	assign pready = ce;
	assign pslverr = psel & penable & (!mapped | reject);

	// Region width registers
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1)
		begin : g_region
			reg [15:0] width_ff;
			always @(posedge clk_sys)
			begin
				if (!nrst)
					width_ff <= `LET_RST_REGION;
				else if (wr && paddr == `LET_OFF_REG0 + g * 4)
					width_ff <= pwdata[15:0];
			end
			assign region_ff[g] = width_ff;
		end
	endgenerate

	// Read data is captured in the setup cycle
	reg [31:0] nxt_prdata;
	always @*
	begin
		nxt_prdata = 32'h0;
		if (sel_ctrl)
			nxt_prdata = {24'h0, ctrl_ff};
		else if (sel_rate)
			nxt_prdata = {16'h0, rate_ff};
		else if (sel_expo)
			nxt_prdata = exp_eff_cyc / `LET_CYC_PER_US; // R2
		else if (sel_stat)
			nxt_prdata = {27'h0, pend_ff, readout, exposing, drop_ff, err_ff};
		else if (sel_reg)
			nxt_prdata = {16'h0, region_ff[paddr[3:2]]};
		else if (sel_per)
			nxt_prdata = period;
		else if (sel_maxr)
			nxt_prdata = max_rate;
	end

	// Line sync edges; the input is synchronous to clk_sys
	wire rise = line_sync_in & !sync_prev_ff;
	wire fall = !line_sync_in & sync_prev_ff;
	wire spaced = line_cnt_ff >= min_space - 32'h1; // R14
	wire idle = state_ff == ST_IDLE;

	reg start;
	reg stop;
	reg nxt_pend;
	reg drop_evt;
	always @*
	begin
		start = 1'b0;
		stop = 1'b0;
		nxt_pend = pend_ff;
		drop_evt = 1'b0;
		if (!trig_en)
		begin
			start = idle && line_cnt_ff >= period - 32'h1; // R1
			stop = !idle && exp_cnt_ff >= exp_eff_cyc - 32'h1;
			nxt_pend = 1'b0;
		end
		else if (pw_mode)
		begin
			start = idle && rise && spaced; // R6 R7
			stop = !idle && fall; // R7
			drop_evt = rise && !(idle && spaced); // R14
			nxt_pend = 1'b0;
		end
		else
		begin
			stop = !idle && exp_cnt_ff >= exp_eff_cyc - 32'h1; // R9 R18
			if (idle && spaced && (fall || pend_ff))
			begin
				start = 1'b1; // R9
				nxt_pend = fall && pend_ff;
			end
			else if (fall)
			begin
				if (!pend_ff)
					nxt_pend = 1'b1; // R11
				else
					drop_evt = 1'b1; // R11 R14
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			ctrl_ff <= `LET_RST_CTRL;
			rate_ff <= `LET_RST_RATE;
			expo_ff <= `LET_RST_EXPO;
			err_ff <= 1'b0;
			drop_ff <= 1'b0;
			pend_ff <= 1'b0;
			state_ff <= ST_IDLE;
			sync_prev_ff <= 1'b0;
			line_cnt_ff <= 32'h0;
			exp_cnt_ff <= 32'h0;
			rd_cnt_ff <= 32'h0;
			prdata <= 32'h0;
			exposing <= 1'b0;
			readout <= 1'b0;
			line_start <= 1'b0;
		end
		else if (ce)
		begin
			sync_prev_ff <= line_sync_in;
			if (psel && !penable)
				prdata <= nxt_prdata;
			if (wr_ctrl)
				// Width mode only holds together with trigger on
				ctrl_ff <= {pwdata[7:2], pwdata[1] & pwdata[0], pwdata[0]}; // R18
			if (wr && sel_rate && rate_ok)
				rate_ff <= pwdata[15:0]; // R12
			if (wr && sel_expo && expo_ok)
				expo_ff <= pwdata[11:0]; // R3 R19
			// Hardware set wins over the write-one clear
			err_ff <= (wr && reject) | (err_ff & !(wr && sel_stat && pwdata[`LET_STAT_ERR])); // R13
			drop_ff <= drop_evt | (drop_ff & !(wr && sel_stat && pwdata[`LET_STAT_DROP])); // R14
			line_start <= start & !wr_ctrl;
			// A mode change abandons the line in flight rather than mixing timings
			if (wr_ctrl)
			begin
				state_ff <= ST_IDLE;
				pend_ff <= 1'b0;
				exposing <= 1'b0;
			end
			else
			begin
				pend_ff <= nxt_pend;
				if (start)
				begin
					state_ff <= ST_EXPO;
					exposing <= 1'b1;
				end
				else if (stop)
				begin
					state_ff <= ST_IDLE;
					exposing <= 1'b0;
				end
			end
			if (start && !wr_ctrl)
				line_cnt_ff <= 32'h0;
			else if (line_cnt_ff != 32'hffffffff)
				line_cnt_ff <= line_cnt_ff + 32'h1;
			if (start)
				exp_cnt_ff <= 32'h0;
			else if (!idle)
				exp_cnt_ff <= exp_cnt_ff + 32'h1;
			if (stop && !wr_ctrl)
			begin
				rd_cnt_ff <= `LET_READOUT_CYC - 32'h1; // R5
				readout <= 1'b1;
			end
			else if (rd_cnt_ff != 32'h0)
				rd_cnt_ff <= rd_cnt_ff - 32'h1;
			else
				readout <= 1'b0;
		end
	end

endmodule

// ---- bench/let_timing_props.sv ----
// Port assertions for the line exposure timing block
`timescale 1ns/1ps
module let_timing_props (
	// Clock and control
	input wire clk_sys,
	input wire nrst,
	input wire ce,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Sensor timing
	input wire line_sync_in,
	input wire exposing,
	input wire readout,
	input wire line_start
);
	reg [15:0] gap_ff;
	reg [15:0] rd_ff;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// Gap saturates so a long idle never wraps into a false short gap
	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			gap_ff <= 16'hffff;
			rd_ff <= 16'h0000;
		end
		else if (ce)
		begin
			gap_ff <= line_start ? 16'h0001 : gap_ff + {15'h0000, gap_ff != 16'hffff};
			rd_ff <= readout ? rd_ff + 16'h0001 : 16'h0000;
		end
	end
	sequence exp_up;
		$rose(exposing);
	endsequence
	// A control write aborts an exposure, so that end is not tied to readout
	sequence exp_end;
		$fell(exposing) && $past(nrst) && !$past(psel && penable && pwrite && paddr == 8'h00);
	endsequence
	pready_ce_a: assert property (pready == ce) else $error("pready not ce");
	err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr idle");
	start_exp_a: assert property (line_start && ce |-> exp_up) else $error("start no exposure");
	exp_start_a: assert property (exp_up |-> line_start) else $error("exposure no start");
	exp_read_a: assert property (exp_end |-> readout) else $error("no readout");
	line_gap_a: assert property (line_start && ce |-> gap_ff >= 16'h015e) else $error("lines close");
	read_len_a: assert property ($fell(readout) && $past(nrst) |-> rd_ff == 16'h015e) else $error("readout len");
	ce_freeze_a: assert property (!ce |=> $stable(exposing) && $stable(readout) && $stable(line_start))
		else $error("ran with ce low");
endmodule
bind let_timing let_timing_props let_timing_props_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .line_sync_in(line_sync_in), .exposing(exposing), .readout(readout), .line_start(line_start));

// ---- bench/let_sync_src.sv ----
// Frame grabber model that drives the line sync
`timescale 1ns/1ps
module let_sync_src (
	// Clock
	input wire clk_sys,
	// Line sync to the block
	output reg line_sync_in
);
	initial line_sync_in = 1'b0;
	// Phases too short are stretched: the grabber never breaks the sync timing
	task automatic pulse(input int hi, input int lo);
		begin
			@(posedge clk_sys);
			line_sync_in <= 1'b1;
			repeat (hi > 150 ? hi : 151) @(posedge clk_sys);
			line_sync_in <= 1'b0;
			repeat (lo > 37 ? lo : 38) @(posedge clk_sys);
		end
	endtask
endmodule

// ---- bench/let_timing_tb.sv ----
// Self-checking bench for the line exposure timing block
`timescale 1ns/1ps
module let_timing_tb;
	reg clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h00000000, rd, seed = 32'h000173f1;
	wire [31:0] prdata;
	wire pready, pslverr, line_sync_in, exposing, readout, line_start;
	int num_errors = 0, num_checks = 0, i, n, t, w0, r;
	int rst_q[$] = '{0, 1000, 100, 0, 1024, 1024, 1024, 1024, 25000, 10000};
	always #20 clk_sys = ~clk_sys;
	let_timing let_timing_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_sync_in(line_sync_in), .exposing(exposing), .readout(readout), .line_start(line_start));
	let_sync_src let_sync_src_i (.clk_sys(clk_sys), .line_sync_in(line_sync_in));
	function automatic int rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[15:0];
	endfunction
	// Line-rate ceiling for a link set-up and summed region width
	function automatic int maxr(int c, int f, int h, int s);
		int m;
		int l;
		m = (h ? 425000000 : 850000000) / ((c == 0 ? 10 : c == 1 ? 5 : c == 2 ? 3 : 2) * s);
		l = c == 0 ? 10000 : c == 1 ? 20000 : c == 3 && !f ? 34000 : 50000;
		return m < l ? m : l;
	endfunction
	task print_verdict(input bit hung);
		begin
			if (hung)
				num_errors++;
			$display("checks %0d errors %0d", num_checks, num_errors);
			if (num_errors == 0 && num_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task automatic chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			num_checks++;
			if (g !== e)
			begin
				num_errors++;
				$display("unexpected %s exp %0h got %0h", nm, e, g);
			end
		end
	endtask
	// Expected value all ones means the caller inspects rd itself
	task automatic ap(input w, input [7:0] a, input [31:0] d, input [31:0] e);
		int k;
		begin
			@(posedge clk_sys);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			@(posedge clk_sys);
			for (k = 0; pready !== 1'b1 && k < 99; k++)
				@(posedge clk_sys);
			if (pready !== 1'b1)
				print_verdict(1);
			rd = w ? {31'h0, pslverr} : prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			if (e !== 32'hffffffff)
				chk(w ? "pslverr" : "prdata", e, rd);
		end
	endtask
	// Waits for a line start, end of exposure, end of readout or quiet sensor
	task automatic wt(input int s, output int n);
		begin
			@(posedge clk_sys);
			for (n = 1; n < 30000 && (s == 0 ? line_start !== 1'b1 : s == 1 ? exposing === 1'b1
				: s == 2 ? readout === 1'b1 : (exposing | readout) !== 1'b0); n++)
				@(posedge clk_sys);
			if (n == 30000)
				print_verdict(1);
		end
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		for (i = 0; i < 10; i++)
			ap(0, 8'(4 * i), 0, rst_q[i]);
		ce <= 1'b0;
		@(posedge clk_sys);
		chk("pready", 0, pready);
		ce <= 1'b1;
		ap(1, 8'h00, 2, 0);
		ap(0, 8'h00, 0, 0);
		w0 = 1024 + rnd() % 7000;
		ap(1, 8'h10, w0, 0);
		for (i = 0; i < 8; i++)
		begin
			r = rnd() % 4;
			t = rnd() % 2;
			ap(1, 8'h00, (r << 6) | (i / 4 << 5) | (t << 4) | (i % 4 << 2), 0);
			ap(0, 8'h24, 0, maxr(i % 4, t, i / 4, w0 + 1024 * r));
		end
		ap(1, 8'h00, 0, 0);
		r = 2000 + rnd() % 3001;
		ap(1, 8'h04, r, 0);
		ap(0, 8'h20, 0, 25000000 / r);
		wt(0, n);
		wt(0, n);
		chk("period", 25000000 / r, n);
		// Ten frozen cycles inside the exposure must stretch it by exactly ten
		ce <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk("pready", 0, pready);
		ce <= 1'b1;
		wt(1, n);
		chk("exposure", 2500, n);
		wt(2, n);
		chk("readout", 350, n);
		ap(1, 8'h04, 0, 1);
		ap(1, 8'h04, 50001, 1);
		ap(1, 8'h04, 50000, 0);
		ap(0, 8'h20, 0, 2500);
		ap(0, 8'h08, 0, 98);
		wt(0, n);
		wt(0, n);
		chk("period", 2500, n);
		wt(1, n);
		chk("exposure", 2461, n);
		ap(1, 8'h0c, 3, 0);
		ap(1, 8'h08, 99, 1);
		ap(1, 8'h08, 7, 1);
		ap(0, 8'h0c, 0, 32'hffffffff);
		chk("err", 1, rd[0]);
		ap(1, 8'h0c, 1, 0);
		ap(0, 8'h0c, 0, 32'hffffffff);
		chk("err", 0, rd[0]);
		ap(1, 8'h08, 98, 0);
		ap(1, 8'h04, 2000, 0);
		wt(3, n);
		ap(1, 8'h00, 1, 0);
		ap(1, 8'h04, 1000, 1);
		ap(1, 8'h08, 3001, 1);
		ap(1, 8'h08, 40, 0);
		ap(1, 8'h0c, 3, 0);
		fork
			repeat (3) let_sync_src_i.pulse(151, 38);
			begin
				wt(0, n);
				wt(1, n);
				chk("exposure", 1000, n);
				wt(0, t);
				chk("gap", 2500, n + t);
			end
		join
		ap(0, 8'h0c, 0, 32'hffffffff);
		chk("drop", 1, rd[1]);
		repeat (2600) @(posedge clk_sys);
		ap(1, 8'h00, 3, 0);
		fork
			let_sync_src_i.pulse(400, 38);
			begin
				wt(0, n);
				wt(1, n);
				chk("exposure", 400, n);
				wt(2, n);
				chk("readout", 350, n);
			end
		join
		nrst <= 1'b0;
		@(posedge clk_sys);
		nrst <= 1'b1;
		ap(0, 8'h00, 0, 0);
		print_verdict(0);
	end
endmodule
